// File: inc/cct_map.svh
// Constants of the compare/capture/PWM timer
`ifndef CCT_MAP_SVH
`define CCT_MAP_SVH

// ----------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------
`define CCT_W_STD     16
`define CCT_W_WIDE    32
`define CCT_MAX_CH    4
`define CCT_DT_W      8

// ----------------------------------------------------------------
// Channel mode encodings
// ----------------------------------------------------------------
`define CCT_MODE_CAP  2'h0
`define CCT_MODE_CMP  2'h1
`define CCT_MODE_PWM  2'h3

// ----------------------------------------------------------------
// Reset values and count sources
// ----------------------------------------------------------------
`define CCT_CNT_RST   '0
`define CCT_SRC_CLK   1'h0
`define CCT_SRC_EVT   1'h1

`endif

// File: inc/cct_pkg.sv
// Types of the compare/capture/PWM timer
`include "cct_map.svh"
package cct_pkg;
  typedef enum logic [1:0] {
    CCT_CAP = `CCT_MODE_CAP,
    CCT_CMP = `CCT_MODE_CMP,
    CCT_PWM = `CCT_MODE_PWM
  } cct_mode_t;
endpackage

// File: rtl/cct_chan.sv
// One compare/capture/PWM channel
`timescale 1ns/1ps
`include "cct_map.svh"
module cct_chan #(
  parameter int WIDTH = `CCT_W_STD
) (
  input  wire  logic              clk_i,
  input  wire  logic              rst_n_i,
  input  wire  logic              en_i,
  input  wire  cct_pkg::cct_mode_t mode_i,
  input  wire  logic [WIDTH-1:0]  cnt_i,
  input  wire  logic              step_i,
  input  wire  logic              wrap_i,
  input  wire  logic              cap_evt_i,
  input  wire  logic              cmp_wr_i,
  input  wire  logic [WIDTH-1:0]  cmp_data_i,
  output logic [WIDTH-1:0]        cap_o,
  output logic                    out_o,
  output logic                    hit_o
);
  import cct_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] cmp;
    logic [WIDTH-1:0] buf_val;
    logic             buf_full;
    logic [WIDTH-1:0] cap;
    logic             out;
  } cct_ch_st_t;

  cct_ch_st_t st;
  cct_ch_st_t next_st;

  // ----------------------------------------------------------------
  // Channel behaviour
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    hit_o   = 1'b0;
    unique case (mode_i)
      CCT_CAP: begin
        next_st.out = 1'b0;
        if (cap_evt_i) begin
          next_st.cap = cnt_i;
          hit_o       = 1'b1;
        end
      end
      CCT_CMP: begin
        if (cmp_wr_i) begin
          next_st.cmp = cmp_data_i;
        end
        next_st.out = (cnt_i >= st.cmp);
        hit_o       = step_i && (cnt_i == st.cmp);
      end
      CCT_PWM: begin
        // New duty waits for the wrap so no period is cut short
        if (wrap_i && st.buf_full) begin
          next_st.cmp      = st.buf_val;
          next_st.buf_full = 1'b0;
        end
        if (cmp_wr_i) begin
          next_st.buf_val  = cmp_data_i;
          next_st.buf_full = 1'b1;
        end
        next_st.out = (cnt_i < st.cmp);
        hit_o       = step_i && (cnt_i == st.cmp);
      end
      default: begin
        next_st.out = 1'b0;
      end
    endcase
    if (!en_i) begin
      hit_o = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else if (en_i) begin
      st <= next_st;
    end
  end

  assign cap_o = st.cap;
  assign out_o = st.out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_buf_load;
    wrap_i && st.buf_full && en_i && mode_i == CCT_PWM;
  endsequence

  property p_capture;
    @(posedge clk_i) disable iff (!rst_n_i)
    (en_i && mode_i == CCT_CAP && cap_evt_i) |=> cap_o == $past(cnt_i);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture missed the counter value");

  property p_compare;
    @(posedge clk_i) disable iff (!rst_n_i)
    (en_i && mode_i == CCT_CMP) |=>
      out_o == ($past(cnt_i) >= $past(st.cmp));
  endproperty
  a_compare: assert property (p_compare)
    else $error("compare output wrong");

  property p_pwm_load;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_buf_load |=> st.cmp == $past(st.buf_val);
  endproperty
  a_pwm_load: assert property (p_pwm_load)
    else $error("buffered compare not loaded at wrap");

  property p_cap_quiet;
    @(posedge clk_i) disable iff (!rst_n_i)
    (en_i && mode_i == CCT_CAP) |=> !out_o;
  endproperty
  a_cap_quiet: assert property (p_cap_quiet)
    else $error("output driven in capture mode");
endmodule // cct_chan

// File: rtl/cct_timer.sv
// Compare/capture/PWM timer unit, standard or wide
//
// Summary of operation
// - Standard unit has one shared sixteen-bit counter.
// - Up to four channels, count is parameter.
// - Each channel is capture, compare or PWM.
// - Capture copies counter on selected input event.
// - Compare output follows counter against threshold.
// - PWM takes the last compare value written before each wrap, at that wrap.
// - Dead-time only on first unit of kind.
// - Wide variant is identical but thirty-two bits.
// - Counts events, emits timing events to network.
`timescale 1ns/1ps
`include "cct_map.svh"
module cct_timer #(
  parameter int WIDTH      = `CCT_W_STD,
  parameter int NCH        = `CCT_MAX_CH,
  parameter bit FIRST_UNIT = 1'b0,
  parameter int DT_W       = `CCT_DT_W
) (
  input  wire  logic                          clk_i,
  input  wire  logic                          rst_n_i,
  input  wire  logic                          en_i,
  input  wire  logic                          run_i,
  input  wire  logic                          cnt_src_i,
  input  wire  logic                          cnt_evt_i,
  input  wire  cct_pkg::cct_mode_t [NCH-1:0]  mode_i,
  input  wire  logic [NCH-1:0]                cap_in_i,
  input  wire  logic [NCH-1:0]                cmp_wr_i,
  input  wire  logic [NCH-1:0][WIDTH-1:0]     cmp_data_i,
  input  wire  logic                          dt_en_i,
  input  wire  logic [DT_W-1:0]               dt_len_i,
  input  wire  logic                          ovf_clr_i,
  input  wire  logic [NCH-1:0]                ch_clr_i,
  output logic [WIDTH-1:0]                    cnt_o,
  output logic [NCH-1:0][WIDTH-1:0]           cap_o,
  output logic [NCH-1:0]                      pwm_p_o,
  output logic [NCH-1:0]                      pwm_n_o,
  output logic                                ovf_evt_o,
  output logic [NCH-1:0]                      ch_evt_o,
  output logic                                ovf_flag_o,
  output logic [NCH-1:0]                      ch_flag_o
);
  import cct_pkg::*;

  // ----------------------------------------------------------------
  // Build checks
  // ----------------------------------------------------------------
  if (WIDTH != `CCT_W_STD && WIDTH != `CCT_W_WIDE) begin : g_bad_w
    $error("WIDTH must be the standard or the wide counter width");
  end
  if (NCH < 1 || NCH > `CCT_MAX_CH) begin : g_bad_n
    $error("NCH out of range");
  end
  if (DT_W < 1) begin : g_bad_dt
    $error("DT_W must be at least one");
  end

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0]          cnt;
    logic [NCH-1:0]            cap_s1;
    logic [NCH-1:0]            cap_s2;
    logic [NCH-1:0]            cap_s3;
    logic [2:0]                evt_s;
    logic                      ovf_evt;
    logic                      ovf_flag;
    logic [NCH-1:0]            ch_evt;
    logic [NCH-1:0]            ch_flag;
    logic [NCH-1:0]            lvl;
    logic [NCH-1:0]            pos;
    logic [NCH-1:0]            neg;
    logic [NCH-1:0][DT_W-1:0]  dt;
  } cct_st_t;

  cct_st_t          st;
  cct_st_t          next_st;
  logic             step;
  logic             wrap;
  logic [NCH-1:0]   cap_evt;
  logic [NCH-1:0]   hit;
  logic [NCH-1:0]   ch_out;

  // Counter advances on the clock or on a synchronised event edge
  assign step = en_i && run_i &&
                ((cnt_src_i == `CCT_SRC_CLK) ||
                 (st.evt_s[1] && !st.evt_s[2]));
  assign wrap = step && (st.cnt == '1);
  assign cap_evt = st.cap_s2 & ~st.cap_s3;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    cct_chan #(
      .WIDTH (WIDTH)
    ) u_chan (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n),
      .en_i       (en_i),
      .mode_i     (mode_i[i]),
      .cnt_i      (st.cnt),
      .step_i     (step),
      .wrap_i     (wrap),
      .cap_evt_i  (cap_evt[i]),
      .cmp_wr_i   (cmp_wr_i[i]),
      .cmp_data_i (cmp_data_i[i]),
      .cap_o      (cap_o[i]),
      .out_o      (ch_out[i]),
      .hit_o      (hit[i])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.cap_s1 = cap_in_i;
    next_st.cap_s2 = st.cap_s1;
    next_st.cap_s3 = st.cap_s2;
    next_st.evt_s  = {st.evt_s[1:0], cnt_evt_i};
    if (step) begin
      next_st.cnt = wrap ? `CCT_CNT_RST : WIDTH'(st.cnt + 1'b1);
    end
    next_st.ovf_evt = wrap;
    next_st.ch_evt  = hit;
    // Set wins over a clear in the same cycle
    next_st.ovf_flag = wrap || (st.ovf_flag && !ovf_clr_i);
    next_st.ch_flag  = hit | (st.ch_flag & ~ch_clr_i);
    for (int i = 0; i < NCH; i++) begin
      if (!(FIRST_UNIT && dt_en_i)) begin
        next_st.lvl[i] = ch_out[i];
        next_st.pos[i] = ch_out[i];
        next_st.neg[i] = !ch_out[i];
        next_st.dt[i]  = '0;
      end else if (ch_out[i] != st.lvl[i]) begin
        next_st.lvl[i] = ch_out[i];
        next_st.pos[i] = 1'b0;
        next_st.neg[i] = 1'b0;
        next_st.dt[i]  = dt_len_i;
      end else if (st.dt[i] != '0) begin
        next_st.dt[i]  = DT_W'(st.dt[i] - 1'b1);
      end else begin
        next_st.pos[i] = st.lvl[i];
        next_st.neg[i] = !st.lvl[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else if (en_i) begin
      st <= next_st;
    end
  end

  assign cnt_o      = st.cnt;
  assign pwm_p_o    = st.pos;
  assign pwm_n_o    = st.neg;
  assign ovf_evt_o  = st.ovf_evt;
  assign ch_evt_o   = st.ch_evt;
  assign ovf_flag_o = st.ovf_flag;
  assign ch_flag_o  = st.ch_flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_clk_step;
    en_i && run_i && cnt_src_i == `CCT_SRC_CLK;
  endsequence

  property p_count;
    @(posedge clk_i) disable iff (!rst_n)
    (s_clk_step and st.cnt != '1) |=> cnt_o == WIDTH'($past(st.cnt) + 1'b1);
  endproperty
  a_count: assert property (p_count)
    else $error("counter did not advance by one");

  property p_wrap;
    @(posedge clk_i) disable iff (!rst_n)
    (s_clk_step and st.cnt == '1) |=> cnt_o == '0 && ovf_evt_o && ovf_flag_o;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap did not clear counter and flag overflow");

  property p_freeze;
    @(posedge clk_i) disable iff (!rst_n)
    !en_i |=> $stable(cnt_o) && $stable(ch_flag_o);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");

  property p_evt_hold;
    @(posedge clk_i) disable iff (!rst_n)
    (en_i && run_i && cnt_src_i == `CCT_SRC_EVT &&
     !(st.evt_s[1] && !st.evt_s[2])) |=> $stable(cnt_o);
  endproperty
  a_evt_hold: assert property (p_evt_hold)
    else $error("counter moved without an event");

  property p_ch_flag;
    @(posedge clk_i) disable iff (!rst_n)
    (en_i && |ch_evt_o) |-> (ch_flag_o & ch_evt_o) == ch_evt_o;
  endproperty
  a_ch_flag: assert property (p_ch_flag)
    else $error("channel event without its flag");

  property p_no_overlap;
    @(posedge clk_i) disable iff (!rst_n)
    (FIRST_UNIT && dt_en_i) |-> (pwm_p_o & pwm_n_o) == '0;
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("complementary outputs high together");

  property p_no_dt;
    @(posedge clk_i) disable iff (!rst_n)
    (!FIRST_UNIT && en_i) |=> pwm_n_o == ~pwm_p_o;
  endproperty
  a_no_dt: assert property (p_no_dt)
    else $error("dead time seen on a unit without it");
endmodule // cct_timer

// File: dv/cct_sink.sv
// Event consumer model on the routing network
`timescale 1ns/1ps
module cct_sink (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        evt_i,
  output logic      [31:0] count_o
);
  // Counts pulses; a level held high would count every cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= '0;
    end else if (evt_i) begin
      count_o <= count_o + 32'h1;
    end
  end
endmodule // cct_sink

// File: dv/tb.sv
// Self-checking bench of the timer unit
`timescale 1ns/1ps
module tb;
  import cct_pkg::*;
  localparam int W = 16;
  logic              clk_i   = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              en      = 1'b1;
  logic              run     = 1'b0;
  logic              src     = 1'b0;
  logic              cevt    = 1'b0;
  logic              dt_en   = 1'b0;
  logic              oclr    = 1'b0;
  logic [3:0]        cclr    = '0;
  logic [7:0]        dlen    = '0;
  logic [3:0]        cap_in  = '0;
  logic [3:0]        wr      = '0;
  logic [3:0][W-1:0] wdat    = '0;
  cct_mode_t [3:0]   mode    = '{CCT_CAP, CCT_PWM, CCT_CMP, CCT_CAP};
  logic [W-1:0]      cnt;
  logic [3:0][W-1:0] cap;
  logic [3:0]        pp;
  logic [3:0]        pn;
  logic [3:0]        cevo;
  logic [3:0]        cflag;
  logic              oevt;
  logic              oflag;
  logic [31:0]       n_ovf;
  logic [7:0]        lf      = 8'h3D;
  logic [W-1:0]      k;
  logic [W-1:0]      e;
  logic [W-1:0]      q[$];
  int                n_fail  = 0;
  int                checked = 0;

  always #5 clk_i = ~clk_i;

  cct_timer #(.WIDTH(W), .NCH(4), .FIRST_UNIT(1'b1), .DT_W(8)) i_cct_timer (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en), .run_i(run),
    .cnt_src_i(src), .cnt_evt_i(cevt), .mode_i(mode), .cap_in_i(cap_in),
    .cmp_wr_i(wr), .cmp_data_i(wdat), .dt_en_i(dt_en), .dt_len_i(dlen),
    .ovf_clr_i(oclr), .ch_clr_i(cclr), .cnt_o(cnt), .cap_o(cap),
    .pwm_p_o(pp), .pwm_n_o(pn), .ovf_evt_o(oevt), .ch_evt_o(cevo),
    .ovf_flag_o(oflag), .ch_flag_o(cflag));

  cct_sink i_cct_sink (.clk_i(clk_i), .rst_n_i(rst_n_i), .evt_i(oevt),
    .count_o(n_ovf));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic cmp_val(input logic [W-1:0] x, input logic [W-1:0] g);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("[FAIL] %0t value %0h expected %0h", $time, g, x);
    end
  endtask

  task automatic cmp_bit(input logic x, input logic g);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("[FAIL] %0t level %b expected %b", $time, g, x);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Counter runs for exactly n sampling edges, then settles
  task automatic step(input int n);
    run = 1'b1;
    cyc(n);
    run = 1'b0;
    cyc(3);
  endtask

  task automatic capt(input int ch, input logic [W-1:0] x);
    q.push_back(x);
    cap_in[ch] = 1'b1;
    cyc(2);
    cap_in[ch] = 1'b0;
    cyc(5);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Result watcher: counter on wrap, captured value on capture
  // ----------------------------------------------------------------
  always @(negedge clk_i) begin
    if (oevt || cevo[0] || cevo[3]) begin
      if (q.size() == 0) begin
        n_fail++;
        $display("[FAIL] %0t unexpected event", $time);
      end else begin
        e = q.pop_front();
        if (oevt) cmp_val(e, cnt);
        else cmp_val(e, cevo[0] ? cap[0] : cap[3]);
      end
    end
  end

  initial begin
    #1000000;
    n_fail++;
    $display("[FAIL] %0t run did not finish", $time);
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(16);
    rst_n_i = 1'b1;
    cyc(5);
    cmp_val('0, cnt);
    lf = lfsr(lf);
    k = {8'h00, lf};
    step(int'(k));
    cmp_val(k, cnt);
    en = 1'b0;
    run = 1'b1;
    cyc(5);
    run = 1'b0;
    en = 1'b1;
    cyc(2);
    cmp_val(k, cnt);
    src = 1'b1;
    run = 1'b1;
    repeat (3) begin
      cevt = 1'b1;
      cyc(2);
      cevt = 1'b0;
      cyc(2);
    end
    cyc(4);
    run = 1'b0;
    src = 1'b0;
    cyc(2);
    k = k + 16'h0003;
    cmp_val(k, cnt);
    capt(0, k);
    cmp_bit(1'b1, cflag[0]);
    cmp_bit(1'b0, pp[0]);
    lf = lfsr(lf);
    step(int'(lf));
    k = k + {8'h00, lf};
    capt(3, k);
    // Clear all channel flags while nothing can set them
    cclr = 4'hF;
    cyc(1);
    cclr = 4'h0;
    cmp_bit(1'b0, cflag[1]);
    cmp_bit(1'b0, cflag[3]);
    // Compare channel: threshold above, then reached
    wdat[1] = k + 16'h0001;
    wr[1] = 1'b1;
    cyc(1);
    wr[1] = 1'b0;
    cyc(4);
    cmp_bit(1'b0, pp[1]);
    cmp_bit(1'b1, pn[1]);
    step(1);
    k = k + 16'h0001;
    cmp_bit(1'b1, pp[1]);
    cmp_bit(1'b0, cflag[1]);
    // Match is flagged as the counter steps off the threshold
    step(1);
    k = k + 16'h0001;
    cmp_bit(1'b1, cflag[1]);
    // Dead band of random length on the first unit as the output falls
    lf = lfsr(lf);
    dlen = {5'h00, lf[2:0]};
    dt_en = 1'b1;
    wdat[1] = k + 16'h0002;
    wr[1] = 1'b1;
    cyc(1);
    wr[1] = 1'b0;
    cyc(2);
    cmp_bit(1'b0, pp[1]);
    cmp_bit(1'b0, pn[1]);
    cyc(int'(dlen));
    cmp_bit(1'b0, pn[1]);
    cyc(1);
    cmp_bit(1'b1, pn[1]);
    dt_en = 1'b0;
    // PWM value is buffered until the wrap
    wdat[2] = k + 16'h0001;
    wr[2] = 1'b1;
    cyc(1);
    wr[2] = 1'b0;
    cyc(4);
    cmp_bit(1'b0, pp[2]);
    q.push_back('0);
    step(65536);
    cmp_val(k, cnt);
    cmp_bit(1'b1, oflag);
    cmp_val(16'h0001, n_ovf[W-1:0]);
    cmp_bit(1'b1, pp[2]);
    cmp_bit(1'b0, pn[2]);
    // Channel moved from capture to compare against a zero threshold
    mode[0] = CCT_CMP;
    cyc(3);
    cmp_bit(1'b1, pp[0]);
    cmp_bit(1'b0, pn[0]);
    oclr = 1'b1;
    cyc(1);
    oclr = 1'b0;
    cyc(2);
    cmp_bit(1'b0, oflag);
    for (int i = 0; i < 20 && q.size() > 0; i++) cyc(1);
    if (q.size() > 0) begin
      n_fail++;
      $display("[FAIL] %0t expected events missing", $time);
    end
    conclude();
  end
endmodule // tb
